// >>> fsr_params.svh
// fsr_params.svh - constants for the five stage shift register
// assumes inclusion by bare name from the package and the design module
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// ----------------------------------------
// geometry and reset values
// ----------------------------------------
`define FSR_STAGES      5
`define FSR_STAGE_RST   5'h00
`define FSR_FIFO_DEPTH  4

`endif

// >>> fsr_pkg.sv
// fsr_pkg.sv - types shared by the five stage shift register
// assumes fsr_params.svh is on the include path
`include "fsr_params.svh"

package fsr_pkg;

  // ----------------------------------------
  // control pins grouped as one carrier
  // ----------------------------------------
  typedef struct packed {
    logic                    clear_n;
    logic                    preset_strobe;
    logic                    serial_in;
    logic [`FSR_STAGES-1:0]  preset_inputs;
  } fsr_pins_t;

  typedef enum logic [1:0] {
    FSR_HOLD,
    FSR_SHIFT,
    FSR_PRESET,
    FSR_CLEAR
  } fsr_mode_t;

endpackage : fsr_pkg

// >>> fsr_shift_register.sv
// fsr_shift_register.sv - five stage shift register with output fifo
// assumes pins come from outside the clk domain; shift_clock is a sampled pin
`timescale 1ns/100ps
`include "fsr_params.svh"

// ----------------------------------------
// fifo holding snapshots of the stages
// ----------------------------------------
module fsr_fifo
  import fsr_pkg::*;
#(
  parameter int WIDTH = `FSR_STAGES,
  parameter int DEPTH = `FSR_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_next;

  // ----------------------------------------
  // occupancy flags and handshakes
  // ----------------------------------------
  // full compares the whole count, so the fifo fills to exactly DEPTH words
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // pointers wrap at the depth, which need not be a power of two
  assign wr_ptr_next = (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
  assign rd_ptr_next = (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
  assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  // storage has no reset; a word is only read after it has been written
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // write side moves only on an accepted push
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  // read side moves only when the consumer takes the head word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // occupancy; a push and a pop in one cycle leave it unchanged
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (clk_en) begin
      count_reg <= count_next;
    end
  end
endmodule // fsr_fifo

// Operation
// - five storage stages chained in order
// - every stage visible on parallel outputs
// - low clear forces all stages low
// - preset input and strobe set stage high
// - shared strobe presets any stage subset
// - shift only on rising clock edge
// - serial into first, each stage shifts on
// - shift needs clear high, strobe low
// - strobe high: stages follow preset inputs
module fsr_shift_register
  import fsr_pkg::*;
#(
  parameter int STAGES = `FSR_STAGES,
  parameter int DEPTH  = `FSR_FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              shift_clock,
  input  wire logic              clear_n,
  input  wire logic              preset_strobe,
  input  wire logic              serial_in,
  input  wire logic [STAGES-1:0] preset_inputs,
  output logic      [STAGES-1:0] stage_outputs,
  output logic                   snap_valid,
  input  wire logic              snap_ready,
  output logic      [STAGES-1:0] snap_data
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  fsr_pins_t        pins_meta_reg;
  fsr_pins_t        pins_reg;
  logic             clk_meta_reg;
  logic             clk_sync_reg;
  logic             clk_prev_reg;
  logic [STAGES-1:0] stage_reg;
  logic [STAGES-1:0] stage_next;
  fsr_mode_t        mode;
  logic             rise;
  logic             fifo_ready;
  logic             stage_change;
  logic [STAGES-1:0] shift_src;

  // two flops on every control and data pin before anything reads them;
  // a reset pin group reads as clear, which matches the reset stage value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_meta_reg <= '0;
      pins_reg      <= '0;
    end else if (clk_en) begin
      pins_meta_reg <= '{clear_n, preset_strobe, serial_in, preset_inputs};
      pins_reg      <= pins_meta_reg;
    end
  end

  // shift clock gets the same two flops, so serial data and edge line up;
  // the third flop only remembers the last level, reset low like an idle pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
    end else if (clk_en) begin
      clk_meta_reg <= shift_clock;
      clk_sync_reg <= clk_meta_reg;
      clk_prev_reg <= clk_sync_reg;
    end
  end

  // ----------------------------------------
  // mode decode and next state
  // ----------------------------------------
  // clear takes priority over preset; both together is undefined for the user anyway
  assign rise = clk_sync_reg && !clk_prev_reg;
  assign mode = !pins_reg.clear_n      ? FSR_CLEAR :
                pins_reg.preset_strobe ? FSR_PRESET :
                rise                   ? FSR_SHIFT :
                                         FSR_HOLD;

  // ----------------------------------------
  // shift path, one stage per iteration
  // ----------------------------------------
  // stage 0 takes the serial pin, every later stage the stage before it
  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    if (i == 0) begin : g_first
      assign shift_src[i] = pins_reg.serial_in;
    end else begin : g_next
      assign shift_src[i] = stage_reg[i-1];
    end
  end

  // one next value per mode; the last stage's old bit falls off the end
  always_comb begin
    case (mode)
      FSR_CLEAR:  stage_next = '0;
      FSR_PRESET: stage_next = pins_reg.preset_inputs;
      FSR_SHIFT:  stage_next = shift_src;
      default:    stage_next = stage_reg;
    endcase
  end

  // a full fifo drops snapshots rather than stalling the stages, as real pins cannot wait
  assign stage_change = (stage_next != stage_reg);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage_reg <= STAGES'(`FSR_STAGE_RST);
    end else if (clk_en) begin
      stage_reg <= stage_next;
    end
  end

  assign stage_outputs = stage_reg;

  // ----------------------------------------
  // snapshot fifo on every stage change
  // ----------------------------------------
  fsr_fifo #(
    .WIDTH (STAGES),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (stage_change),
    .in_ready  (fifo_ready),
    .in_data   (stage_next),
    .out_valid (snap_valid),
    .out_ready (snap_ready),
    .out_data  (snap_data)
  );
endmodule // fsr_shift_register

// >>> fsr_shift_register_assertions.sv
// checker: stage and fifo outputs against pin history
// assumes pins reach the stages three clk edges late
`timescale 1ns/100ps
module fsr_checker
  import fsr_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic       shift_clock,
  input wire logic       clear_n,
  input wire logic       preset_strobe,
  input wire logic       serial_in,
  input wire logic [4:0] preset_inputs,
  input wire logic [4:0] stage_outputs,
  input wire logic       snap_valid,
  input wire logic       snap_ready,
  input wire logic [4:0] snap_data
);
  // windows of 4 to 6 cycles cover the sync delay
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);
  a_clear_low: assert property ((!clear_n)[*4] |-> stage_outputs == 5'h00) else $error("clear");
  a_preset_follow: assert property ((clear_n && preset_strobe && $stable(preset_inputs))[*4]
    |-> stage_outputs == preset_inputs) else $error("preset");
  a_hold_still: assert property ((clear_n && !preset_strobe && !shift_clock)[*6]
    |-> $stable(stage_outputs)) else $error("moved");
  a_shift_on: assert property ((clear_n && !preset_strobe)[*5] ##0 $changed(stage_outputs)
    |-> {stage_outputs[4:1], 1'b0} == 5'($past(stage_outputs) << 1)) else $error("shift");
  a_serial_first: assert property ((clear_n && !preset_strobe && $stable(serial_in))[*5]
    ##0 $changed(stage_outputs) |-> stage_outputs[0] == serial_in) else $error("serial");
  a_snap_flag: assert property ($changed(stage_outputs) |-> snap_valid) else $error("flag");
  a_snap_word: assert property ($changed(stage_outputs) && !$past(snap_valid)
    |-> snap_data == stage_outputs) else $error("word");
  a_snap_hold: assert property (snap_valid && !snap_ready |=> $stable(snap_data)) else $error("head");
endmodule // fsr_checker
bind fsr_shift_register fsr_checker chk (
  .clk           (clk),
  .sys_rst       (sys_rst),
  .clk_en        (clk_en),
  .shift_clock   (shift_clock),
  .clear_n       (clear_n),
  .preset_strobe (preset_strobe),
  .serial_in     (serial_in),
  .preset_inputs (preset_inputs),
  .stage_outputs (stage_outputs),
  .snap_valid    (snap_valid),
  .snap_ready    (snap_ready),
  .snap_data     (snap_data)
);

// >>> fsr_pin_driver.sv
// far side: drives the pin group one mode at a time
// assumes the bench changes mode just after clk edges
`timescale 1ns/100ps
module fsr_pin_driver
  import fsr_pkg::*;
(
  input  wire logic       clk,
  input  wire fsr_mode_t  mode,
  input  wire logic [4:0] pdata,
  input  wire logic       sbit,
  output fsr_pins_t       pins,
  output logic            shift_clock
);
  logic [1:0] ph_reg = 2'h0;
  // shift clock stands low between shifts: 2 cycles low, 2 high
  always_ff @(posedge clk) begin
    ph_reg <= (mode == FSR_SHIFT) ? ph_reg + 2'h1 : 2'h0;
    shift_clock <= (mode == FSR_SHIFT) && ph_reg[1];
    pins.clear_n <= mode != FSR_CLEAR;
    pins.preset_strobe <= mode == FSR_PRESET;
    if (ph_reg == 2'h0) pins.serial_in <= sbit;
    if (mode == FSR_PRESET) pins.preset_inputs <= pdata;
  end
endmodule // fsr_pin_driver

// >>> fsr_shift_register_bench.sv
// bench: pin driver as far side, integer model of the stages
// assumes clk_en is dropped once, with no shift pending, to check the freeze
`timescale 1ns/100ps
module fsr_shift_register_bench
  import fsr_pkg::*;
;
  logic       clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, snap_ready = 1'b1, sbit = 1'b0, sc, sv, sc_last;
  logic [4:0] pdata = 5'h00, so, sd, got[$];
  fsr_mode_t  mode = FSR_CLEAR;
  fsr_pins_t  pins;
  int         model, errors, n_compared, cyc;
  always #5 clk = ~clk;
  fsr_pin_driver drv (.clk, .mode, .pdata, .sbit, .pins, .shift_clock(sc));
  fsr_shift_register dut (.clk, .sys_rst, .clk_en, .shift_clock(sc), .clear_n(pins.clear_n),
    .preset_strobe(pins.preset_strobe), .serial_in(pins.serial_in), .preset_inputs(pins.preset_inputs),
    .stage_outputs(so), .snap_valid(sv), .snap_ready, .snap_data(sd));
  // model: clear over preset over shift, frozen with clk_en; also bounds the run
  always @(posedge clk) begin
    sc_last <= sc;
    if (clk_en) begin
      if (!pins.clear_n) model = 0;
      else if (pins.preset_strobe) model = pins.preset_inputs;
      else if (sc && !sc_last) model = (model * 2 + pins.serial_in) % 32;
    end
    if (++cyc > 3000) begin errors++; give_verdict(); end
  end
  // pops logged on the falling edge, clear of the popping edge
  always @(negedge clk) if (clk_en && sv && snap_ready) got.push_back(sd);
  task automatic check(string what, logic [4:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin errors++; $display("mismatch %s expected %h seen %h", what, exp, seen); end
  endtask
  task automatic run(fsr_mode_t m, int n);
    mode <= m;
    repeat (n) @(posedge clk);
    mode <= FSR_HOLD;
    repeat (8) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hA947));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) begin pdata <= 5'($urandom); run(FSR_PRESET, 6); check("preset", so, 5'(model)); end
    $display("preset done");
    repeat (8) begin sbit <= 1'($urandom); run(FSR_SHIFT, 4); check("shift", so, 5'(model)); end
    $display("shift done");
    repeat (6) begin sbit <= 1'($urandom); @(posedge clk); end
    check("hold", so, 5'(model));
    pdata <= 5'h1F;
    run(FSR_PRESET, 6);
    clk_en <= 1'b0;
    run(FSR_CLEAR, 6);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk);
    check("freeze", so, 5'(model));
    run(FSR_CLEAR, 6);
    check("clear", so, 5'h00);
    $display("hold and clear done");
    snap_ready <= 1'b0;
    got.delete();
    for (int i = 0; i < 6; i++) begin sbit <= ~i[0]; run(FSR_SHIFT, 4); end
    snap_ready <= 1'b1;
    repeat (8) @(posedge clk);
    check("fifo count", 5'(got.size()), 5'h04);
    check("fifo first", got[0], 5'h01);
    check("fifo second", got[1], 5'h02);
    check("fifo third", got[2], 5'h05);
    check("fifo last", got[3], 5'h0A);
    $display("fifo done");
    give_verdict();
  end
endmodule // fsr_shift_register_bench
